//--- rtl/asu_defines.vh
// asu_defines.vh: register map, field positions and reset values of the
// accumulator subtract unit; included by every design file of the block.
`ifndef ASU_DEFINES_VH
`define ASU_DEFINES_VH

// register byte addresses (one aligned word each)
`define ASU_ADDR_ACC      12'h000
`define ASU_ADDR_OPERAND  12'h004
`define ASU_ADDR_CMD      12'h008
`define ASU_ADDR_STATUS   12'h00C
`define ASU_ADDR_RESULT   12'h010

// command field positions
`define ASU_CMD_GO        0
`define ASU_CMD_TO_MEM    1

// status field positions
`define ASU_ST_C          0
`define ASU_ST_AC         1
`define ASU_ST_Z          2
`define ASU_ST_OV         3
`define ASU_ST_MEMWR      4
`define ASU_ST_BUSY       5

// reset values
`define ASU_ACC_RST       8'h00
`define ASU_FLAGS_RST     4'h0
`define ASU_OPERAND_RST   8'h00

// cycles from command to result written back
`define ASU_EXEC_CYCLES   2'h1

`endif

//--- rtl/asu_sub8.v
// asu_sub8.v: combinational 8-bit subtractor with flag outputs.
// assumes operands are stable for the cycle in which they are used.
`timescale 1ns/100ps
`include "asu_defines.vh"

module asu_sub8
(
	input  wire [7:0] minuend,
	input  wire [7:0] subtrahend,
	output wire [7:0] diff,
	output wire       carry,
	output wire       half_carry,
	output wire       zero,
	output wire       overflow
);

	wire [8:0] full_w;
	wire [4:0] low_w;

	// carry set means no borrow, as in a 6502-style subtract
	assign full_w     = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
	assign low_w      = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]}
		+ 5'h01;
	assign diff       = full_w[7:0];
	assign carry      = full_w[8];
	assign half_carry = low_w[4];
	assign zero       = (full_w[7:0] == 8'h00);
	assign overflow   = (minuend[7] != subtrahend[7]) &&
		(full_w[7] != minuend[7]);

endmodule // asu_sub8

//--- rtl/asu_top.v
// asu_top.v: subtract slice of an 8-bit core, reached over APB.
// assumes one APB master on pclk; the memory byte is delivered by software
// in the operand register and taken back from the result register.
`timescale 1ns/100ps
`include "asu_defines.vh"

module asu_top
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg  [7:0]  accumulator_reg,
	output reg  [7:0]  mem_wdata,
	output reg         mem_we,
	output reg         carry_flag,
	output reg         half_carry_flag,
	output reg         zero_flag,
	output reg         overflow_flag
);

	reg  [7:0] operand_r;
	reg        go_r;
	reg        to_mem_r;
	reg        mem_written_r;
	reg  [7:0] result_r;
	wire [7:0] diff_w;
	wire       c_w;
	wire       ac_w;
	wire       z_w;
	wire       ov_w;
	wire       setup_w;
	wire       wr_w;
	reg  [31:0] rd_nxt;
	reg        hit_nxt;

	function is_mapped;
		input [11:0] a;
		begin
			is_mapped = (a == `ASU_ADDR_ACC) || (a == `ASU_ADDR_OPERAND) ||
				(a == `ASU_ADDR_CMD) || (a == `ASU_ADDR_STATUS) ||
				(a == `ASU_ADDR_RESULT);
		end
	endfunction

	asu_sub8 u_sub
	(
		.minuend    (accumulator_reg),
		.subtrahend (operand_r),
		.diff       (diff_w),
		.carry      (c_w),
		.half_carry (ac_w),
		.zero       (z_w),
		.overflow   (ov_w)
	);

	// no wait state: answer comes in the first access cycle
	assign setup_w = psel && !penable;
	assign wr_w    = psel && penable && pready && pwrite;

	always @*
	begin
		rd_nxt  = 32'h00000000;
		hit_nxt = is_mapped(paddr);
		case (paddr)
		`ASU_ADDR_ACC:     rd_nxt = {24'h000000, accumulator_reg};
		`ASU_ADDR_OPERAND: rd_nxt = {24'h000000, operand_r};
		`ASU_ADDR_CMD:     rd_nxt = {30'h00000000, to_mem_r, 1'b0};
		`ASU_ADDR_STATUS:  rd_nxt = {26'h0000000, go_r, mem_written_r,
			overflow_flag, zero_flag, half_carry_flag, carry_flag};
		`ASU_ADDR_RESULT:  rd_nxt = {24'h000000, result_r};
		default:           rd_nxt = 32'h00000000;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else
		begin
			pready  <= setup_w;
			pslverr <= setup_w && !hit_nxt;
			if (setup_w && !pwrite)
				prdata <= rd_nxt;
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			accumulator_reg <= `ASU_ACC_RST;
			operand_r       <= `ASU_OPERAND_RST;
			go_r            <= 1'b0;
			to_mem_r        <= 1'b0;
			mem_written_r   <= 1'b0;
			result_r        <= 8'h00;
			mem_wdata       <= 8'h00;
			mem_we          <= 1'b0;
			{overflow_flag, zero_flag, half_carry_flag, carry_flag}
				<= `ASU_FLAGS_RST;
		end
		else
		begin
			mem_we <= 1'b0;
			if (go_r)
			begin
				go_r            <= 1'b0;
				result_r        <= diff_w;
				carry_flag      <= c_w;
				half_carry_flag <= ac_w;
				zero_flag       <= z_w;
				overflow_flag   <= ov_w;
				if (to_mem_r)
				begin
					// accumulator deliberately held on this form
					mem_wdata     <= diff_w;
					mem_we        <= 1'b1;
					mem_written_r <= 1'b1;
				end
				else
				begin
					accumulator_reg <= diff_w;
					mem_written_r   <= 1'b0;
				end
			end
			else if (wr_w)
			begin
				// writes during execution are ignored to keep operands steady
				case (paddr)
				`ASU_ADDR_ACC:     accumulator_reg <= pwdata[7:0];
				`ASU_ADDR_OPERAND: operand_r <= pwdata[7:0];
				`ASU_ADDR_CMD:
				begin
					to_mem_r <= pwdata[`ASU_CMD_TO_MEM];
					go_r     <= pwdata[`ASU_CMD_GO];
				end
				default:           go_r <= 1'b0;
				endcase
			end
		end
	end

endmodule // asu_top

//--- verif/asu_checker.sv
`timescale 1ns/100ps
// asu_checker: results and flags at the asu_top ports
// assumes results land one edge after the command access edge and are sampled at the second
module asu_checker(
	input logic pclk,
	input logic presetn,
	input logic pwrite,
	input logic pready,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [7:0] accumulator_reg,
	input logic [7:0] mem_wdata,
	input logic mem_we,
	input logic carry_flag,
	input logic half_carry_flag,
	input logic zero_flag,
	input logic overflow_flag
);
	logic [7:0] a_r, o_r;
	// only a write that sets go starts a subtract
	wire cmd = pready && pwrite && paddr == 12'h008 && pwdata[0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always @(posedge pclk)
	begin
		if (pready && pwrite && paddr == 12'h004)
			o_r <= pwdata[7:0];
		if (cmd)
			a_r <= accumulator_reg;
	end
	AST_ACC_FORM: assert property(
		cmd && !pwdata[1] |-> ##2 !mem_we && accumulator_reg == a_r - o_r)
		else $error("acc form");
	AST_MEM_FORM: assert property(
		cmd && pwdata[1] |-> ##2 mem_we && mem_wdata == a_r - o_r
		&& $stable(accumulator_reg)) else $error("mem form");
	AST_CARRY: assert property(
		cmd |-> ##2 carry_flag == (a_r >= o_r)) else $error("carry");
	AST_FLAGS: assert property(
		cmd |-> ##2 zero_flag == (a_r == o_r)
		&& half_carry_flag == (a_r[3:0] >= o_r[3:0])) else $error("flags");
	AST_OVERFLOW: assert property(
		cmd |-> ##2 overflow_flag == ((a_r[7] ^ o_r[7]) &&
		(a_r[7] ^ (a_r - o_r) >> 7))) else $error("overflow");
	AST_QUIET: assert property(
		!$stable({carry_flag, half_carry_flag, zero_flag, overflow_flag})
		|-> $past(cmd, 2)) else $error("flags moved");
	cover property(cmd && pwdata[1]);
	cover property(cmd && !pwdata[1]);
	cover property(mem_we && !carry_flag);
endmodule // asu_checker
bind asu_top asu_checker chk(.*);

//--- verif/asu_mem_model.sv
`timescale 1ns/100ps
// asu_mem_model: data memory byte behind the slice
// assumes mem_we is a one-cycle pulse on pclk
module asu_mem_model(
	input logic       pclk,
	input logic       mem_we,
	input logic [7:0] mem_wdata,
	output logic [7:0] mem_byte
);
	always @(posedge pclk)
		if (mem_we)
			mem_byte <= mem_wdata;
endmodule // asu_mem_model

//--- verif/tb_accumulator_subtract_unit.sv
`timescale 1ns/100ps
// tb: random subtracts of both forms over APB
// assumes asu_top, asu_mem_model and the bound checker
module tb_accumulator_subtract_unit;
	logic pclk=0, presetn=0, psel=0, penable=0, pwrite=0, p1=0, p2=0, er;
	logic pready, pslverr, mem_we, carry_flag, half_carry_flag;
	logic zero_flag, overflow_flag;
	logic [11:0] paddr=0;
	logic [31:0] pwdata=0, prdata, rd;
	logic [7:0] accumulator_reg, mem_wdata, mem_byte, a, o, d;
	logic [15:0] lf=16'h9D8E;
	logic [20:0] q[$];
	int num_errors=0, comparisons=0, cyc=0;
	wire [20:0] got={mem_we, accumulator_reg, mem_we ? mem_wdata : 8'h00,
		carry_flag, half_carry_flag, zero_flag, overflow_flag};
	asu_top uut(.*);
	asu_mem_model mem(.*);
	initial forever #5 pclk = ~pclk;
	function logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15]^s[13]^s[12]^s[10]};
	endfunction
	task chk(input logic [31:0] g, x);
		comparisons++;
		if (g !== x)
		begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask
	task apb(input logic [11:0] ad, input logic [7:0] wd, input logic w);
		@(posedge pclk);
		psel <= 1;
		paddr <= ad;
		pwdata <= {24'h0, wd};
		pwrite <= w;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		er = pslverr;
		rd = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task stop_test;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// results settle one edge after the command access edge and are checked at the second
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		p1 <= pready && pwrite && paddr == 12'h008;
		p2 <= p1;
		if (p2)
			chk(got, q.pop_front());
		if (cyc == 3000)
		begin
			num_errors++;
			stop_test;
		end
	end
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 24; i++)
		begin
			lf = nx(lf);
			a = lf[7:0];
			o = i ? lf[15:8] : a;
			d = a - o;
			q.push_back({i[0], i[0] ? a : d, i[0] ? d : 8'h00, a >= o,
				a[3:0] >= o[3:0], d == 0, (a[7]^o[7]) & (d[7]^a[7])});
			apb(12'h000, a, 1);
			apb(12'h004, o, 1);
			apb(12'h008, {6'h0, i[0], 1'b1}, 1);
		end
		apb(12'h040, 8'h00, 0);
		chk(er, 1);
		chk(rd, 0);
		apb(12'h000, 8'h00, 0);
		chk(rd, {24'h0, a});
		apb(12'h010, 8'h00, 0);
		chk(rd, {24'h0, d});
		repeat (3) @(posedge pclk);
		chk(mem_byte, d);
		stop_test;
	end
endmodule // tb_accumulator_subtract_unit
